// ---- rtcsc_pkg.sv ----
// Purpose: Shared constants for the RTC status register and time counters
// Assumes: 100 MHz system clock, 32.768 kHz oscillator tick on a pin
// Notes:   Offsets are register indices on the local register port
package rtcsc_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] RTCSC_OFF_SECONDS = 4'h0;
  localparam logic [3:0] RTCSC_OFF_MINUTES = 4'h1;
  localparam logic [3:0] RTCSC_OFF_HOURS   = 4'h2;
  localparam logic [3:0] RTCSC_OFF_OSC_ADJ = 4'h7;
  localparam logic [3:0] RTCSC_OFF_CTRL1   = 4'hE;
  localparam logic [3:0] RTCSC_OFF_CTRL2   = 4'hF;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int C2_THR_SEL  = 7;
  localparam int C2_LOW_FLAG = 6;
  localparam int C2_OSC_OK   = 5;
  localparam int C2_POWER_ON = 4;
  localparam int C2_SCRATCH  = 3;
  localparam int C2_PER_FLAG = 2;
  localparam int C2_WK_FLAG  = 1;
  localparam int C2_DY_FLAG  = 0;
  localparam int C1_WK_EN    = 7;
  localparam int C1_DY_EN    = 6;
  localparam int C1_MODE_24  = 5;
  localparam int C1_CT_MSB   = 2;

  // Writable masks of the time counters
  localparam logic [7:0] RTCSC_SEC_MASK  = 8'h7F;
  localparam logic [7:0] RTCSC_MIN_MASK  = 8'h7F;
  localparam logic [7:0] RTCSC_HOUR_MASK = 8'h3F;

  // ----------------------------------------------------------------
  // Reset values and periodic cycle codes
  // ----------------------------------------------------------------
  localparam logic [7:0] RTCSC_CTRL_RESET = 8'h00;
  localparam logic [7:0] RTCSC_TIME_RESET = 8'h00;
  localparam logic       RTCSC_PWR_RESET  = 1'b1;
  localparam logic       RTCSC_OSC_RESET  = 1'b0;
  localparam logic [2:0] CT_OFF    = 3'h0;
  localparam logic [2:0] CT_LOW    = 3'h1;
  localparam logic [2:0] CT_2HZ    = 3'h2;
  localparam logic [2:0] CT_1HZ    = 3'h3;
  localparam logic [2:0] CT_SEC    = 3'h4;
  localparam logic [2:0] CT_MIN    = 3'h5;
  localparam logic [2:0] CT_HOUR   = 3'h6;
  localparam logic [2:0] CT_MONTH  = 3'h7;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS     = 10;
  localparam int ALARM_DELAY_NS    = 31000;
  localparam int ALARM_DELAY_CYC   = ALARM_DELAY_NS / CLK_PERIOD_NS;
  localparam logic [14:0] DIV_LAST = 15'h7FFF;

endpackage

// ---- rtcsc_core.sv ----
// Purpose: Status/control registers, supply and oscillator monitors,
//          interrupt flags and BCD time counters of a serial RTC
// Assumes: Serial bus slave outside decodes into the register port
// Notes:   Read data is registered, one cycle after the address
// Functional notes
// - Threshold select 0 picks higher supply threshold, 1 picks lower.
// - Supply below threshold sets low flag, which holds and stops monitoring.
// - Writing 0 clears low flag and restarts monitoring; writing 1 does nothing.
// - Oscillator-ok bit is read/write; halt clears it, stays 0 until written.
// - Power-on flag set at power-up, stays 1 until software clears it.
// - While power-on flag is 1, control bits are forced 0, except two.
// - Power-on flag cleared only by writing 0; writing 1 ignored.
// - Scratch bit stores written value; cleared while power-on flag is set.
// - Periodic flag reads 1 while periodic interrupt holds the pin low.
// - Level mode: writing 0 clears periodic flag until next cycle; 1 ignored.
// - Enabled alarm match sets its flag about 31 us later; pin follows.
// - Alarm flag cleared by writing 0 or by clearing its enable, until next match; 1 ignored.
// - Alarm flag reads 0 while its enable is 0.
// - Seconds count BCD 00 to 59, carrying into minutes on wrap.
// - Minutes count BCD 00 to 59, carrying into hours on wrap.
// - Hours carry into day counters at 23 to 00 or PM11 to AM12.
// - Any seconds write resets the sub-second divider.
// - 12-hour mode: AM 12,01-11; PM 32,21-31; bit 5 marks PM.
`timescale 1ns/1ps
module rtcsc_core
  import rtcsc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [3:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic       osc_tick_pin,
  input  wire logic       supply_below_high_pin,
  input  wire logic       supply_below_low_pin,
  input  wire logic       osc_halt_pin,
  input  wire logic       weekly_alarm_match,
  input  wire logic       daily_alarm_match,
  input  wire logic       month_start,
  output logic            day_carry,
  output logic            interrupt_out_n_o,
  output logic            interrupt_out_n_oe
);
  import rtcsc_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // BCD increment of a two-digit value
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    end else begin
      bcd_inc = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction

  // Write strobe for one register
  function automatic logic wr_hit(input logic [3:0] off);
    wr_hit = reg_wr && (reg_addr == off);
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic       tick_prev_q;
  logic       tick_s;
  logic       below_hi_s;
  logic       below_lo_s;
  logic       halt_s;

  // Two flops per pin, then edge history for the oscillator tick
  always_ff @(posedge clk) begin
    if (reset) begin
      sync1_q     <= 4'h0;
      sync2_q     <= 4'h0;
      tick_prev_q <= 1'b0;
    end else begin
      sync1_q     <= {osc_halt_pin, supply_below_low_pin,
                      supply_below_high_pin, osc_tick_pin};
      sync2_q     <= sync1_q;
      tick_prev_q <= sync2_q[0];
    end
  end

  assign tick_s     = sync2_q[0] && !tick_prev_q;
  assign below_hi_s = sync2_q[1];
  assign below_lo_s = sync2_q[2];
  assign halt_s     = sync2_q[3];

  // ----------------------------------------------------------------
  // Control state
  // ----------------------------------------------------------------
  logic       power_on_q;
  logic       osc_ok_q;
  logic       thr_sel_q;
  logic       low_flag_q;
  logic       scratch_q;
  logic [7:0] ctrl1_q;
  logic [7:0] osc_adj_q;
  logic       wr_c2;
  logic       supply_low;

  assign wr_c2 = wr_hit(RTCSC_OFF_CTRL2);

  // Power-on flag: set at power-up, write of 0 only clears
  always_ff @(posedge clk) begin
    if (reset) begin
      power_on_q <= RTCSC_PWR_RESET;
    end else if (wr_c2 && !reg_wdata[C2_POWER_ON]) begin
      power_on_q <= 1'b0;
    end
  end

  // Oscillator-ok monitor; a halt wins over a write
  always_ff @(posedge clk) begin
    if (reset) begin
      osc_ok_q <= RTCSC_OSC_RESET;
    end else if (halt_s) begin
      osc_ok_q <= 1'b0;
    end else if (wr_c2) begin
      osc_ok_q <= reg_wdata[C2_OSC_OK];
    end
  end

  // Control register 1 and oscillation adjust, forced 0 by power-on flag
  always_ff @(posedge clk) begin
    if (reset || power_on_q) begin
      ctrl1_q   <= RTCSC_CTRL_RESET;
      osc_adj_q <= RTCSC_CTRL_RESET;
    end else begin
      if (wr_hit(RTCSC_OFF_CTRL1)) begin
        ctrl1_q <= reg_wdata;
      end
      if (wr_hit(RTCSC_OFF_OSC_ADJ)) begin
        osc_adj_q <= reg_wdata;
      end
    end
  end

  // Threshold select and scratch bit
  always_ff @(posedge clk) begin
    if (reset || power_on_q) begin
      thr_sel_q <= 1'b0;
      scratch_q <= 1'b0;
    end else if (wr_c2) begin
      thr_sel_q <= reg_wdata[C2_THR_SEL];
      scratch_q <= reg_wdata[C2_SCRATCH];
    end
  end

  // Supply monitor: comparator picked by threshold select
  assign supply_low = thr_sel_q ? below_lo_s : below_hi_s;

  // Low-supply flag: sticky, monitoring stops while set
  always_ff @(posedge clk) begin
    if (reset || power_on_q) begin
      low_flag_q <= 1'b0;
    end else if (!low_flag_q && supply_low) begin
      low_flag_q <= 1'b1;
    end else if (wr_c2 && !reg_wdata[C2_LOW_FLAG]) begin
      low_flag_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Time counters
  // ----------------------------------------------------------------
  logic [14:0] div_q;
  logic [7:0]  sec_q;
  logic [7:0]  min_q;
  logic [7:0]  hour_q;
  logic        sec_tick;
  logic        sec_wrap;
  logic        min_wrap;
  logic        hour_wrap;
  logic        mode24;
  logic [7:0]  hour_next;

  assign mode24    = ctrl1_q[C1_MODE_24];
  assign sec_tick  = tick_s && (div_q == DIV_LAST);
  assign sec_wrap  = sec_tick && (sec_q == 8'h59);
  assign min_wrap  = sec_wrap && (min_q == 8'h59);
  assign hour_wrap = min_wrap && (mode24 ? (hour_q == 8'h23) : (hour_q == 8'h31));

  // Sub-second divider, cleared by any seconds write
  always_ff @(posedge clk) begin
    if (reset || wr_hit(RTCSC_OFF_SECONDS)) begin
      div_q <= 15'h0000;
    end else if (tick_s) begin
      div_q <= div_q + 15'h0001;
    end
  end

  // Seconds counter
  always_ff @(posedge clk) begin
    if (reset) begin
      sec_q <= RTCSC_TIME_RESET;
    end else if (wr_hit(RTCSC_OFF_SECONDS)) begin
      sec_q <= reg_wdata & RTCSC_SEC_MASK;
    end else if (sec_tick) begin
      sec_q <= sec_wrap ? 8'h00 : bcd_inc(sec_q);
    end
  end

  // Minutes counter
  always_ff @(posedge clk) begin
    if (reset) begin
      min_q <= RTCSC_TIME_RESET;
    end else if (wr_hit(RTCSC_OFF_MINUTES)) begin
      min_q <= reg_wdata & RTCSC_MIN_MASK;
    end else if (sec_wrap) begin
      min_q <= min_wrap ? 8'h00 : bcd_inc(min_q);
    end
  end

  // Next hour value in either mode
  always_comb begin
    hour_next = bcd_inc(hour_q);
    if (mode24) begin
      if (hour_q == 8'h23) begin
        hour_next = 8'h00;
      end
    end else begin
      unique case (hour_q)
        8'h11:   hour_next = 8'h32;
        8'h12:   hour_next = 8'h01;
        8'h31:   hour_next = 8'h12;
        8'h32:   hour_next = 8'h21;
        default: hour_next = bcd_inc(hour_q);
      endcase
    end
  end

  // Hours counter and day carry pulse
  always_ff @(posedge clk) begin
    if (reset) begin
      hour_q    <= RTCSC_TIME_RESET;
      day_carry <= 1'b0;
    end else begin
      day_carry <= hour_wrap;
      if (wr_hit(RTCSC_OFF_HOURS)) begin
        hour_q <= reg_wdata & RTCSC_HOUR_MASK;
      end else if (min_wrap) begin
        hour_q <= hour_next;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt flags
  // ----------------------------------------------------------------
  logic [2:0]  ct_mode;
  logic        per_event;
  logic        per_level_q;
  logic        per_flag;
  logic        wk_flag_q;
  logic        dy_flag_q;
  logic [11:0] wk_cnt_q;
  logic [11:0] dy_cnt_q;

  assign ct_mode = ctrl1_q[C1_CT_MSB:0];

  // Periodic event for the level modes
  always_comb begin
    unique case (ct_mode)
      CT_SEC:   per_event = sec_tick;
      CT_MIN:   per_event = sec_wrap;
      CT_HOUR:  per_event = min_wrap;
      CT_MONTH: per_event = month_start;
      default:  per_event = 1'b0;
    endcase
  end

  // Level-mode flag; an event wins over a clearing write
  always_ff @(posedge clk) begin
    if (reset || power_on_q || !ct_mode[2]) begin
      per_level_q <= 1'b0;
    end else if (per_event) begin
      per_level_q <= 1'b1;
    end else if (wr_c2 && !reg_wdata[C2_PER_FLAG]) begin
      per_level_q <= 1'b0;
    end
  end

  // Periodic flag mirrors the periodic output in every mode
  always_comb begin
    unique case (ct_mode)
      CT_OFF:  per_flag = 1'b0;
      CT_LOW:  per_flag = 1'b1;
      CT_2HZ:  per_flag = !div_q[13];
      CT_1HZ:  per_flag = !div_q[14];
      default: per_flag = per_level_q;
    endcase
  end

  // Alarm delay counters: start on match, flag set when they expire
  always_ff @(posedge clk) begin
    if (reset || !ctrl1_q[C1_WK_EN]) begin
      wk_cnt_q <= 12'h000;
    end else if (weekly_alarm_match && wk_cnt_q == 12'h000) begin
      wk_cnt_q <= 12'(ALARM_DELAY_CYC);
    end else if (wk_cnt_q != 12'h000) begin
      wk_cnt_q <= wk_cnt_q - 12'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (reset || !ctrl1_q[C1_DY_EN]) begin
      dy_cnt_q <= 12'h000;
    end else if (daily_alarm_match && dy_cnt_q == 12'h000) begin
      dy_cnt_q <= 12'(ALARM_DELAY_CYC);
    end else if (dy_cnt_q != 12'h000) begin
      dy_cnt_q <= dy_cnt_q - 12'h001;
    end
  end

  // Alarm flags: held 0 while disabled, set wins over clear
  always_ff @(posedge clk) begin
    if (reset || !ctrl1_q[C1_WK_EN]) begin
      wk_flag_q <= 1'b0;
    end else if (wk_cnt_q == 12'h001) begin
      wk_flag_q <= 1'b1;
    end else if (wr_c2 && !reg_wdata[C2_WK_FLAG]) begin
      wk_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset || !ctrl1_q[C1_DY_EN]) begin
      dy_flag_q <= 1'b0;
    end else if (dy_cnt_q == 12'h001) begin
      dy_flag_q <= 1'b1;
    end else if (wr_c2 && !reg_wdata[C2_DY_FLAG]) begin
      dy_flag_q <= 1'b0;
    end
  end

  // Open-drain interrupt pin: pulls low while the periodic flag or either alarm flag is up
  assign interrupt_out_n_o  = 1'b0;
  assign interrupt_out_n_oe = per_flag || wk_flag_q || dy_flag_q;

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else begin
      unique case (reg_addr)
        RTCSC_OFF_SECONDS: reg_rdata <= sec_q & RTCSC_SEC_MASK;
        RTCSC_OFF_MINUTES: reg_rdata <= min_q & RTCSC_MIN_MASK;
        RTCSC_OFF_HOURS:   reg_rdata <= hour_q & RTCSC_HOUR_MASK;
        RTCSC_OFF_OSC_ADJ: reg_rdata <= osc_adj_q;
        RTCSC_OFF_CTRL1:   reg_rdata <= ctrl1_q;
        RTCSC_OFF_CTRL2:   reg_rdata <= {thr_sel_q, low_flag_q, osc_ok_q, power_on_q,
                                         scratch_q, per_flag, wk_flag_q, dy_flag_q};
        default:           reg_rdata <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_power_forces_ctrl: assert property (@(posedge clk) disable iff (reset)
    power_on_q |=> ctrl1_q == 8'h00 && !thr_sel_q && !scratch_q && !interrupt_out_n_oe)
    else $error("control bits not cleared under power-on flag");

  a_power_no_set: assert property (@(posedge clk) disable iff (reset)
    !power_on_q |=> !power_on_q)
    else $error("power-on flag rose after being cleared");

  a_low_flag_hold: assert property (@(posedge clk) disable iff (reset)
    low_flag_q && !power_on_q && !(wr_c2 && !reg_wdata[C2_LOW_FLAG]) |=> low_flag_q)
    else $error("low-supply flag dropped without a clearing write");

  a_osc_halt_clear: assert property (@(posedge clk) disable iff (reset)
    halt_s |=> !osc_ok_q)
    else $error("oscillator-ok bit not cleared by halt");

  a_alarm_gated: assert property (@(posedge clk) disable iff (reset)
    !ctrl1_q[C1_WK_EN] |=> !wk_flag_q)
    else $error("weekly alarm flag up while disabled");

  a_alarm_delay: assert property (@(posedge clk) disable iff (reset)
    ctrl1_q[C1_DY_EN] && daily_alarm_match && dy_cnt_q == 12'h000 && !power_on_q
    |=> dy_cnt_q == 12'(ALARM_DELAY_CYC))
    else $error("daily alarm delay not loaded");

  a_sec_wrap: assert property (@(posedge clk) disable iff (reset)
    sec_wrap && !reg_wr |=> sec_q == 8'h00 && min_q != $past(min_q))
    else $error("seconds wrap without minute carry");

  a_div_clear: assert property (@(posedge clk) disable iff (reset)
    reg_wr && reg_addr == RTCSC_OFF_SECONDS |=> div_q == 15'h0000)
    else $error("divider not reset by seconds write");

  a_hour_pm11: assert property (@(posedge clk) disable iff (reset)
    !mode24 && hour_q == 8'h31 && min_wrap && !reg_wr |=> hour_q == 8'h12 && day_carry)
    else $error("PM11 to AM12 rollover wrong");

endmodule

// ---- rtcsc_host.sv ----
// Purpose: Host model that reaches the registers over the register port
// Assumes: A write is taken on the edge with reg_wr high; read data is registered
// Notes:   Write data is not held after its strobe, so late sampling shows up
`timescale 1ns/1ps
module rtcsc_host (
  input  wire logic       clk,
  output logic      [3:0] reg_addr,
  output logic            reg_wr,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  // Idle bus at time zero
  initial begin
    reg_addr  = 4'h0;
    reg_wr    = 1'b0;
    reg_wdata = 8'h00;
  end

  // ------------------------------------------------------------
  // Register accesses
  // ------------------------------------------------------------
  // One write, strobe high for exactly one edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wr    <= 1'b1;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr    <= 1'b0;
    reg_wdata <= ~d; // Stale data inverted once released
  endtask

  // Address one cycle, data taken after the registering edge
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    @(posedge clk);
    #1;
    d = reg_rdata;
  endtask
endmodule

// ---- rtc_status_and_time_counters_tb.sv ----
// Purpose: Self-checking bench for the status register and time counters
// Assumes: Oscillator pin toggled every clock so one second is 65536 cycles
// Notes:   Only one full second is run to keep the run short
`timescale 1ns/1ps
module rtc_status_and_time_counters_tb;
  import rtcsc_pkg::*;
  localparam logic [3:0] C1 = RTCSC_OFF_CTRL1;
  localparam logic [3:0] C2 = RTCSC_OFF_CTRL2;
  localparam int         LIMIT = 90000;
  logic       clk, reset, osc_tick_pin, osc_halt_pin, month_start;
  logic       supply_below_high_pin, supply_below_low_pin;
  logic       weekly_alarm_match, daily_alarm_match, reg_wr, day_carry;
  logic       interrupt_out_n_o, interrupt_out_n_oe;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  int         n_mismatch, n_checks, cycles, carries;

  // ------------------------------------------------------------
  // Instances
  // ------------------------------------------------------------
  rtcsc_host host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  rtcsc_core dut (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .osc_tick_pin(osc_tick_pin),
    .supply_below_high_pin(supply_below_high_pin),
    .supply_below_low_pin(supply_below_low_pin), .osc_halt_pin(osc_halt_pin),
    .weekly_alarm_match(weekly_alarm_match), .daily_alarm_match(daily_alarm_match),
    .month_start(month_start), .day_carry(day_carry),
    .interrupt_out_n_o(interrupt_out_n_o), .interrupt_out_n_oe(interrupt_out_n_oe));

  // Clock generation
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Cycle count, carry pulses and hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (day_carry === 1'b1) begin
      carries <= carries + 1;
    end
    if (cycles == LIMIT) begin
      n_mismatch++;
      end_sim();
    end
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t pin got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host.rd(a, d);
    chk8(d, exp);
  endtask

  task automatic waitc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Rising oscillator edges, then let the synchronizer settle
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk) osc_tick_pin <= 1'b1;
      @(posedge clk) osc_tick_pin <= 1'b0;
    end
    waitc(4);
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    {reset, osc_tick_pin, osc_halt_pin, month_start} = 4'h8;
    {supply_below_high_pin, supply_below_low_pin} = 2'h0;
    {weekly_alarm_match, daily_alarm_match} = 2'h0;
    {n_mismatch, n_checks, cycles, carries} = '0;
    waitc(4);
    reset <= 1'b0;
    // Power-up state and forced control bits
    rdchk(C2, 8'h10);
    rdchk(RTCSC_OFF_SECONDS, RTCSC_TIME_RESET);
    rdchk(4'h3, 8'h00);
    chk1(interrupt_out_n_oe, 1'b0);
    chk1(interrupt_out_n_o, 1'b0);
    host.wr(C1, 8'hFF);
    rdchk(C1, 8'h00);
    host.wr(C2, 8'hFF);
    rdchk(C2, 8'h30);
    // Scratch write lost on the edge that clears the power-on flag
    host.wr(C2, 8'h28);
    rdchk(C2, 8'h20);
    host.wr(C2, 8'h38);
    rdchk(C2, 8'h28);
    host.wr(C2, 8'h20);
    rdchk(C2, 8'h20);
    // Supply monitor, higher threshold selected
    @(posedge clk) supply_below_high_pin <= 1'b1;
    waitc(4);
    rdchk(C2, 8'h60);
    host.wr(C2, 8'h20);
    rdchk(C2, 8'h60);
    @(posedge clk) supply_below_high_pin <= 1'b0;
    waitc(4);
    rdchk(C2, 8'h60);
    host.wr(C2, 8'h20);
    rdchk(C2, 8'h20);
    host.wr(C2, 8'h60);
    rdchk(C2, 8'h20);
    // Lower threshold selected
    host.wr(C2, 8'hA0);
    @(posedge clk) supply_below_high_pin <= 1'b1;
    waitc(4);
    rdchk(C2, 8'hA0);
    @(posedge clk) supply_below_low_pin <= 1'b1;
    waitc(4);
    rdchk(C2, 8'hE0);
    @(posedge clk) {supply_below_high_pin, supply_below_low_pin} <= 2'h0;
    host.wr(C2, 8'h20);
    rdchk(C2, 8'h20);
    // Oscillation halt beats writes and sticks
    @(posedge clk) osc_halt_pin <= 1'b1;
    waitc(4);
    host.wr(C2, 8'h20);
    rdchk(C2, 8'h00);
    @(posedge clk) osc_halt_pin <= 1'b0;
    waitc(4);
    rdchk(C2, 8'h00);
    host.wr(C2, 8'h20);
    rdchk(C2, 8'h20);
    // Periodic flag: fixed low, off, monthly level mode
    host.wr(C1, {5'h00, CT_LOW});
    rdchk(C2, 8'h24);
    chk1(interrupt_out_n_oe, 1'b1);
    host.wr(C1, {5'h00, CT_OFF});
    rdchk(C2, 8'h20);
    chk1(interrupt_out_n_oe, 1'b0);
    host.wr(C1, {5'h00, CT_MONTH});
    @(posedge clk) month_start <= 1'b1;
    @(posedge clk) month_start <= 1'b0;
    rdchk(C2, 8'h24);
    chk1(interrupt_out_n_oe, 1'b1);
    host.wr(C2, 8'h20);
    rdchk(C2, 8'h20);
    chk1(interrupt_out_n_oe, 1'b0);
    // Alarms, delay about 3100 cycles
    host.wr(C1, 8'hC0);
    @(posedge clk) weekly_alarm_match <= 1'b1;
    @(posedge clk) weekly_alarm_match <= 1'b0;
    waitc(3000);
    rdchk(C2, 8'h20);
    waitc(150);
    rdchk(C2, 8'h22);
    chk1(interrupt_out_n_oe, 1'b1);
    host.wr(C2, 8'h20);
    rdchk(C2, 8'h20);
    chk1(interrupt_out_n_oe, 1'b0);
    @(posedge clk) daily_alarm_match <= 1'b1;
    @(posedge clk) daily_alarm_match <= 1'b0;
    waitc(3150);
    host.wr(C2, 8'h23);
    rdchk(C2, 8'h21);
    host.wr(C1, 8'h80);
    rdchk(C2, 8'h20);
    host.wr(C2, 8'h20);
    // Time counters, 12-hour mode, per-second flag
    host.wr(C1, {5'h00, CT_SEC});
    host.wr(RTCSC_OFF_HOURS, 8'hF1);
    rdchk(RTCSC_OFF_HOURS, 8'h31);
    host.wr(RTCSC_OFF_MINUTES, 8'hD9);
    rdchk(RTCSC_OFF_MINUTES, 8'h59);
    ticks(100);
    host.wr(RTCSC_OFF_SECONDS, 8'hD9);
    rdchk(RTCSC_OFF_SECONDS, 8'h59);
    // Half a second in: 1 Hz output released, 2 Hz output low again
    ticks(16384);
    host.wr(C1, {5'h00, CT_1HZ});
    rdchk(C2, 8'h20);
    host.wr(C1, {5'h00, CT_2HZ});
    rdchk(C2, 8'h24);
    host.wr(C1, {5'h00, CT_SEC});
    ticks(16383);
    rdchk(RTCSC_OFF_SECONDS, 8'h59);
    chk8(8'(carries), 8'h00);
    ticks(1);
    rdchk(RTCSC_OFF_SECONDS, 8'h00);
    rdchk(RTCSC_OFF_MINUTES, 8'h00);
    rdchk(RTCSC_OFF_HOURS, 8'h12);
    rdchk(C2, 8'h24);
    chk8(8'(carries), 8'h01);
    end_sim();
  end
endmodule
